// file: bus_term_defs.svh
// Purpose: timing and encoding constants for bus cycle termination
// Assumes: one 20 MHz clock, all termination inputs change on rising edges
// Notes:   outcome codes are one-hot
`ifndef BUS_TERM_DEFS_SVH
`define BUS_TERM_DEFS_SVH
`define CLK_PERIOD_NS   50
`define LATE_GAP_CYC    1
`define OUT_NORMAL      4'h1
`define OUT_HALT        4'h2
`define OUT_FAULT       4'h4
`define OUT_RETRY       4'h8
`define ILLEGAL_VECTOR  8'h00
`define FAULT_VECTOR    8'h02
`endif

// file: bus_term_pkg.sv
// Purpose: shared types for bus cycle termination
// Assumes: nothing
// Notes:   none
package bus_term_pkg;
  typedef logic [3:0] outcome_t;
endpackage

// file: bus_term_if.sv
// Purpose: termination handshake between processor and slaves
// Assumes: active-low signals, all on clk
// Notes:   no clocking block
`timescale 1ns/100ps
`default_nettype none
interface bus_term_if (
  input wire logic clk  // processor clock
);
  logic addrStrobe_n;   // cycle in progress
  logic transferAck_n;  // slave acknowledge
  logic busFault_n;     // fault
  logic stall_n;        // halt request
  modport cpu   (input transferAck_n, busFault_n, stall_n, output addrStrobe_n);
  modport slave (output transferAck_n, busFault_n, stall_n, input addrStrobe_n);
endinterface
`default_nettype wire

// file: bus_term_cpu.sv
// Purpose: processor end; classifies how each bus cycle ends
// Assumes: inputs sampled at the even bus state edge, one clk per state pair
// Notes:   the state sequence itself lives elsewhere; start/done are handshakes
`timescale 1ns/100ps
`default_nettype none
`include "bus_term_defs.svh"
// How it works
// - far side changes inputs on rising edges
// - sample inputs at state N and N+2
// - ack alone gives normal completion
// - stall with ack halts until released
// - fault without stall gives bus error
// - late fault at N+2 optional trap
// - far side releases fault after ack; the slave drops both on one edge
// - fault plus stall requests a retry
// - late fault plus stall optional retry
// - proper release order reruns the cycle
// - improper release order traps vector zero
// - lingering fault/stall stretch next cycle
// - stuck fault ends next cycle as error
// - far side releases on strobe negation
// - watchdog asserts fault on timeout
// - checker withholds ack, then retries
// - late fault one cycle after ack
// - error ends read in S9, RMW write S21
// - float buses in retry, repeat cycle
// - never retry read-modify-write cycles
module bus_term_cpu #(
  parameter bit LATE_EN = 1'b1  // late fault/retry recognition
) (
  input  wire logic  clk,          // 20 MHz clock
  input  wire logic  rst,          // async reset, active high
  bus_term_if.cpu    bus,          // termination pins
  input  wire logic  cycleStart,   // request to run a bus cycle
  input  wire logic  isRmw,        // cycle is read-modify-write
  input  wire logic  rmwWrite,     // in write part of rmw
  output logic       outValid,     // one-cycle outcome strobe
  output logic [3:0] outcome,      // one-hot outcome
  output logic       busFloat,     // address/data buses floated
  output logic       halted,       // processor halted
  output logic       rerun,        // one-cycle rerun pulse
  output logic       illegalTrap,  // one-cycle trap pulse
  output logic [7:0] trapVector,   // exception vector number
  output logic [4:0] endState      // state number the last bus-error cycle ended in
);
  typedef enum logic [5:0] {
    IDLE  = 6'b000001,
    WAITN = 6'b000010,
    LATE  = 6'b000100,
    HOLD  = 6'b001000,
    RTRY  = 6'b010000,
    RELS  = 6'b100000
  } st_e;

  logic ack1_r, ack2_r, flt1_r, flt2_r, stl1_r, stl2_r;
  logic ack, flt, stl;
  st_e state_r, state_nxt;
  logic as_r, as_nxt, ov_r, ov_nxt, fl_r, fl_nxt, hl_r, hl_nxt;
  logic rr_r, rr_nxt, il_r, il_nxt, rmw_r, rmw_nxt, wr_r, wr_nxt;
  logic fltEarly_r, fltEarly_nxt;
  bus_term_pkg::outcome_t oc_r, oc_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic [4:0] es_r, es_nxt;

  // two-flop synchronisers; asynchronous slaves may violate setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ack1_r, ack2_r, flt1_r, flt2_r, stl1_r, stl2_r} <= 6'h00;
    end else begin
      ack1_r <= ~bus.transferAck_n;
      ack2_r <= ack1_r;
      flt1_r <= ~bus.busFault_n;
      flt2_r <= flt1_r;
      stl1_r <= ~bus.stall_n;
      stl2_r <= stl1_r;
    end
  end
  assign ack = ack2_r;
  assign flt = flt2_r;
  assign stl = stl2_r;

  function automatic logic [4:0] faultEnd(input logic w);
    faultEnd = w ? 5'h15 : 5'h09;
  endfunction

  always_comb begin
    state_nxt    = state_r;
    as_nxt       = as_r;
    ov_nxt       = 1'b0;
    oc_nxt       = oc_r;
    fl_nxt       = fl_r;
    hl_nxt       = hl_r;
    rr_nxt       = 1'b0;
    il_nxt       = 1'b0;
    rmw_nxt      = rmw_r;
    wr_nxt       = wr_r;
    vec_nxt      = vec_r;
    es_nxt       = es_r;
    fltEarly_nxt = fltEarly_r;
    case (state_r)
      IDLE: begin
        if (cycleStart && !hl_r) begin
          as_nxt       = 1'b1;
          rmw_nxt      = isRmw;
          wr_nxt       = rmwWrite;
          fltEarly_nxt = flt;  // fault still held from prior cycle
          state_nxt    = WAITN;
        end
      end
      WAITN: begin  // edge of state N; waits stretch here
        // a fault still held from the last cycle ends this one at once; one that has dropped holds off ack a cycle
        fltEarly_nxt = fltEarly_r && flt;
        if (flt && (!stl || rmw_r)) begin
          oc_nxt    = `OUT_FAULT;
          vec_nxt   = `FAULT_VECTOR;
          es_nxt    = faultEnd(wr_r);
          ov_nxt    = 1'b1;
          as_nxt    = 1'b0;
          state_nxt = IDLE;
        end else if (flt && stl) begin
          oc_nxt    = `OUT_RETRY;
          ov_nxt    = 1'b1;
          as_nxt    = 1'b0;
          fl_nxt    = 1'b1;
          state_nxt = RTRY;
        end else if (ack && !fltEarly_r) begin
          if (LATE_EN) begin
            state_nxt = LATE;
          end else begin
            oc_nxt    = stl ? `OUT_HALT : `OUT_NORMAL;
            ov_nxt    = 1'b1;
            as_nxt    = 1'b0;
            hl_nxt    = stl;
            fl_nxt    = stl;
            state_nxt = stl ? HOLD : IDLE;
          end
        end
      end
      LATE: begin  // edge of state N+2
        as_nxt = 1'b0;
        ov_nxt = 1'b1;
        if (flt && stl && !rmw_r) begin
          oc_nxt    = `OUT_RETRY;
          fl_nxt    = 1'b1;
          state_nxt = RTRY;
        end else if (flt) begin
          oc_nxt    = `OUT_FAULT;
          vec_nxt   = `FAULT_VECTOR;
          es_nxt    = faultEnd(wr_r);
          state_nxt = IDLE;
        end else begin
          oc_nxt    = stl ? `OUT_HALT : `OUT_NORMAL;
          hl_nxt    = stl;
          fl_nxt    = stl;
          state_nxt = stl ? HOLD : IDLE;
        end
      end
      HOLD: begin  // halted until stall released
        if (!stl) begin
          hl_nxt    = 1'b0;
          fl_nxt    = 1'b0;
          state_nxt = IDLE;
        end
      end
      RTRY: begin  // fault must drop while stall held
        if (!flt && stl) begin
          state_nxt = RELS;
        end else if (!stl) begin
          il_nxt    = 1'b1;
          vec_nxt   = `ILLEGAL_VECTOR;
          fl_nxt    = 1'b0;
          state_nxt = IDLE;
        end
      end
      RELS: begin
        if (flt) begin
          state_nxt = RTRY;
        end else if (!stl) begin  // rerun with same cycle
          rr_nxt       = 1'b1;
          fl_nxt       = 1'b0;
          as_nxt       = 1'b1;
          fltEarly_nxt = 1'b0;
          state_nxt    = WAITN;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= IDLE;
      as_r       <= 1'b0;
      ov_r       <= 1'b0;
      oc_r       <= 4'h0;
      fl_r       <= 1'b0;
      hl_r       <= 1'b0;
      rr_r       <= 1'b0;
      il_r       <= 1'b0;
      rmw_r      <= 1'b0;
      wr_r       <= 1'b0;
      vec_r      <= 8'h00;
      es_r       <= 5'h00;
      fltEarly_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      as_r       <= as_nxt;
      ov_r       <= ov_nxt;
      oc_r       <= oc_nxt;
      fl_r       <= fl_nxt;
      hl_r       <= hl_nxt;
      rr_r       <= rr_nxt;
      il_r       <= il_nxt;
      rmw_r      <= rmw_nxt;
      wr_r       <= wr_nxt;
      vec_r      <= vec_nxt;
      es_r       <= es_nxt;
      fltEarly_r <= fltEarly_nxt;
    end
  end

  assign bus.addrStrobe_n = ~as_r;
  assign outValid         = ov_r;
  assign outcome          = oc_r;
  assign busFloat         = fl_r;
  assign halted           = hl_r;
  assign rerun            = rr_r;
  assign illegalTrap      = il_r;
  assign trapVector       = vec_r;
  assign endState         = es_r;
endmodule
`default_nettype wire

// file: bus_term_slave.sv
// Purpose: slave/control end; drives termination per user command
// Assumes: cmd sampled when a cycle is seen in progress
// Notes:   all outputs change on rising edges only
`timescale 1ns/100ps
`default_nettype none
`include "bus_term_defs.svh"
module bus_term_slave (
  input  wire logic  clk,      // 20 MHz clock
  input  wire logic  rst,      // async reset, active high
  bus_term_if.slave  bus,      // termination pins
  input  wire logic  respGo,   // answer the current cycle now
  input  wire logic  late,     // send fault one cycle after ack
  input  wire logic  wantFlt,  // answer with fault
  input  wire logic  wantStl,  // add stall (halt or retry)
  input  wire logic  stlDrop,  // release stall for halt/retry
  output logic       busy      // answer in progress
);
  logic as1_r, as2_r;
  logic ack_r, ack_nxt, flt_r, flt_nxt, stl_r, stl_nxt;
  logic lt_r, lt_nxt, bz_r, bz_nxt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      as1_r <= 1'b0;
      as2_r <= 1'b0;
    end else begin
      as1_r <= ~bus.addrStrobe_n;
      as2_r <= as1_r;
    end
  end

  always_comb begin
    ack_nxt = ack_r;
    flt_nxt = flt_r;
    stl_nxt = stl_r;
    lt_nxt  = 1'b0;
    bz_nxt  = bz_r;
    if (as2_r && respGo && !bz_r) begin
      bz_nxt  = 1'b1;
      ack_nxt = !wantFlt || late;
      flt_nxt = wantFlt && !late;
      stl_nxt = wantStl;
      lt_nxt  = wantFlt && late;
    end
    if (lt_r) begin
      flt_nxt = 1'b1;  // one cycle after ack
    end
    if (!as2_r && bz_r) begin  // release on strobe negation
      ack_nxt = 1'b0;
      flt_nxt = 1'b0;
      if (!stl_r || stlDrop || !flt_r) begin
        bz_nxt = stl_r && !stlDrop;
      end
    end
    if (stl_r && stlDrop && !flt_r && !flt_nxt) begin
      stl_nxt = 1'b0;  // stall outlasts fault by a cycle
      bz_nxt  = ack_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      flt_r <= 1'b0;
      stl_r <= 1'b0;
      lt_r  <= 1'b0;
      bz_r  <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      flt_r <= flt_nxt;
      stl_r <= stl_nxt;
      lt_r  <= lt_nxt;
      bz_r  <= bz_nxt;
    end
  end

  assign bus.transferAck_n = ~ack_r;
  assign bus.busFault_n    = ~flt_r;
  assign bus.stall_n       = ~stl_r;
  assign busy              = bz_r;
endmodule
`default_nettype wire

// file: bus_term_checker.sv
// Purpose: wire-level checks of the termination handshake between both ends
// Assumes: one clock, rst asynchronous and active high
// Notes:   pins are active low
`timescale 1ns/100ps
`default_nettype none
module bus_term_checker (
  input wire logic clk,            // processor clock
  input wire logic rst,            // async reset
  input wire logic addrStrobe_n,   // cycle in progress
  input wire logic transferAck_n,  // acknowledge
  input wire logic busFault_n,     // fault
  input wire logic stall_n         // halt request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_in_cycle: assert property ($fell(transferAck_n) |-> !addrStrobe_n)
    else $error("ack raised outside a cycle");
  chk_fault_in_cycle: assert property ($fell(busFault_n) |-> !addrStrobe_n)
    else $error("fault raised outside a cycle");
  chk_fault_after_ack: assert property ($rose(busFault_n) |-> transferAck_n)
    else $error("fault released before ack");
  chk_stall_after_fault: assert property ($rose(stall_n) |-> $past(busFault_n))
    else $error("stall released too early");
  chk_ack_ends_cycle: assert property (
    !addrStrobe_n && !transferAck_n && busFault_n && stall_n |-> ##[1:8] addrStrobe_n)
    else $error("ack did not end the cycle");
  chk_fault_ends_cycle: assert property (!addrStrobe_n && !busFault_n |-> ##[1:8] addrStrobe_n)
    else $error("fault did not end the cycle");
  // synchroniser lag: only a stall seen for four cycles must block a start
  chk_halt_blocks_start: assert property (!stall_n[*4] ##0 addrStrobe_n |=> addrStrobe_n)
    else $error("cycle started while halted");
  // slave sees the strobe through two flops, so ack drops one edge after that
  chk_ack_released: assert property (addrStrobe_n[*4] |-> transferAck_n)
    else $error("ack held after strobe release");
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench; one pair of ends plus a cpu end driven by the bench
// Assumes: 20 MHz clock, rst held 16 cycles
// Notes:   the second cpu end has late recognition off and takes illegal sequences
`timescale 1ns/100ps
`default_nettype none
`include "bus_term_defs.svh"
module tb;
  logic       clk = 1'h0, rst = 1'h1, cycleStart = 1'h0, cycleStart2 = 1'h0;
  logic       isRmw = 1'h0, rmwWrite = 1'h0, respGo = 1'h0, late = 1'h0;
  logic       wantFlt = 1'h0, wantStl = 1'h0, stlDrop = 1'h0;
  logic       outValid, halted, busFloat, rerun, busy, outValid2, illegalTrap2;
  logic [3:0] outcome, outcome2;
  logic [7:0] trapVector, trapVector2;
  logic [4:0] endState;
  int         n_mismatch = 0, checks_done = 0, cyc = 0;
  bus_term_if i_bus_term_if (.clk(clk));
  bus_term_if i_bus_term_if_b (.clk(clk));
  wire logic [6:0] ev = {halted, !i_bus_term_if_b.addrStrobe_n, illegalTrap2, outValid2,
                         !busy && !halted, rerun, outValid};
  bus_term_cpu i_bus_term_cpu (.clk(clk), .rst(rst), .bus(i_bus_term_if.cpu), .cycleStart(cycleStart),
    .isRmw(isRmw), .rmwWrite(rmwWrite), .outValid(outValid), .outcome(outcome), .busFloat(busFloat),
    .halted(halted), .rerun(rerun), .illegalTrap(), .trapVector(trapVector), .endState(endState));
  bus_term_cpu #(.LATE_EN(1'h0)) i_bus_term_cpu_b (.clk(clk), .rst(rst), .bus(i_bus_term_if_b.cpu),
    .cycleStart(cycleStart2), .isRmw(1'h0), .rmwWrite(1'h0), .outValid(outValid2), .outcome(outcome2),
    .busFloat(), .halted(), .rerun(), .illegalTrap(illegalTrap2), .trapVector(trapVector2), .endState());
  bus_term_slave i_bus_term_slave (.clk(clk), .rst(rst), .bus(i_bus_term_if.slave), .respGo(respGo),
    .late(late), .wantFlt(wantFlt), .wantStl(wantStl), .stlDrop(stlDrop), .busy(busy));
  bus_term_checker i_bus_term_checker (.clk(clk), .rst(rst), .addrStrobe_n(i_bus_term_if.addrStrobe_n),
    .transferAck_n(i_bus_term_if.transferAck_n), .busFault_n(i_bus_term_if.busFault_n),
    .stall_n(i_bus_term_if.stall_n));
  always #25 clk = ~clk;
  // whole run needs a few hundred cycles; far above that means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic waitFor(input int s);
    int k;
    k = 0;
    while (ev[s] !== 1'h1 && k < 80) begin
      @(negedge clk);
      k++;
    end
    if (k == 80) cmp("wait", 8'h01, 8'h00);
  endtask
  // m = {rmw, late, stall, fault}
  task automatic go(input logic [3:0] m, input logic [3:0] e);
    waitFor(2);
    @(posedge clk);
    {isRmw, late, wantStl, wantFlt} <= m;
    rmwWrite <= m[3];
    cycleStart <= 1'h1;
    @(posedge clk);
    cycleStart <= 1'h0;
    respGo <= 1'h1;
    waitFor(0);
    cmp("outcome", {4'h0, e}, {4'h0, outcome});
    @(posedge clk);
    respGo <= 1'h0;
  endtask
  task automatic drop_stall();
    @(posedge clk);
    {isRmw, rmwWrite, late, wantStl, wantFlt} <= 5'h00;
    stlDrop <= 1'h1;
  endtask
  task automatic pins(input logic k, input logic f, input logic s);
    @(posedge clk);  // far-side pins move on rising edges only
    i_bus_term_if_b.transferAck_n <= k;
    i_bus_term_if_b.busFault_n <= f;
    i_bus_term_if_b.stall_n <= s;
  endtask
  task automatic start2();
    repeat (6) @(posedge clk);
    cycleStart2 <= 1'h1;
    @(posedge clk);
    cycleStart2 <= 1'h0;
  endtask
  task automatic t_normal();
    go(4'h0, `OUT_NORMAL);
    go(4'h0, `OUT_NORMAL);
  endtask
  task automatic t_late_fault();
    go(4'h5, `OUT_FAULT);
  endtask
  task automatic t_fault();
    go(4'h1, `OUT_FAULT);
    cmp("vector", `FAULT_VECTOR, trapVector);
    cmp("endState", 8'h09, {3'h0, endState});
  endtask
  task automatic t_rmw();
    go(4'hB, `OUT_FAULT);
    cmp("endState", 8'h15, {3'h0, endState});
    drop_stall();
    waitFor(2);
    @(posedge clk);
    stlDrop <= 1'h0;
  endtask
  task automatic t_halt();
    go(4'h2, `OUT_HALT);
    waitFor(6);
    cmp("busFloat", 8'h01, {7'h00, busFloat});
    drop_stall();
    waitFor(2);
    @(posedge clk);
    stlDrop <= 1'h0;
  endtask
  task automatic t_retry(input logic lt);
    go({1'h0, lt, 2'h3}, `OUT_RETRY);
    cmp("busFloat", 8'h01, {7'h00, busFloat});
    drop_stall();
    waitFor(1);
    @(posedge clk);
    stlDrop <= 1'h0;
    respGo <= 1'h1;
    waitFor(0);
    cmp("rerun outcome", {4'h0, `OUT_NORMAL}, {4'h0, outcome});
    @(posedge clk);
    respGo <= 1'h0;
  endtask
  task automatic t_late_off(input logic s);
    start2();
    waitFor(5);
    pins(1'h0, 1'h1, 1'h1);
    pins(1'h0, 1'h0, s);
    waitFor(3);
    cmp("outcome2", {4'h0, `OUT_NORMAL}, {4'h0, outcome2});
    pins(1'h1, 1'h1, s);
    pins(1'h1, 1'h1, 1'h1);
  endtask
  task automatic t_illegal();
    start2();
    waitFor(5);
    pins(1'h0, 1'h0, 1'h0);
    waitFor(3);
    cmp("outcome2", {4'h0, `OUT_RETRY}, {4'h0, outcome2});
    pins(1'h1, 1'h0, 1'h0);
    pins(1'h1, 1'h0, 1'h1);
    waitFor(4);
    cmp("vector2", `ILLEGAL_VECTOR, trapVector2);
    pins(1'h1, 1'h1, 1'h1);
  endtask
  task automatic t_stuck();
    start2();
    waitFor(5);
    pins(1'h0, 1'h1, 1'h1);
    waitFor(3);
    pins(1'h1, 1'h0, 1'h1);
    start2();
    waitFor(3);
    cmp("stuck outcome2", {4'h0, `OUT_FAULT}, {4'h0, outcome2});
    cmp("stuck vector2", `FAULT_VECTOR, trapVector2);
    pins(1'h1, 1'h1, 1'h1);
  endtask
  initial begin
    pins(1'h1, 1'h1, 1'h1);
    repeat (15) @(posedge clk);
    rst <= 1'h0;
    t_normal();
    t_fault();
    t_rmw();
    t_halt();
    t_retry(1'h0);
    t_retry(1'h1);
    t_late_fault();
    t_late_off(1'h1);
    t_late_off(1'h0);
    t_stuck();
    t_illegal();
    repeat (10) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
